// File: hw/bcd_consts.svh
`ifndef BCD_CONSTS_SVH
`define BCD_CONSTS_SVH

// Clock and channel timing
`define BCD_CLK_NS 20
`define BCD_T1_NS 100
`define BCD_T3_NS 100
`define BCD_CLR_NS 1000
`define BCD_T1_CYC ((`BCD_T1_NS + `BCD_CLK_NS - 1) / `BCD_CLK_NS)
`define BCD_T3_CYC ((`BCD_T3_NS + `BCD_CLK_NS - 1) / `BCD_CLK_NS)
`define BCD_CLR_CYC ((`BCD_CLR_NS + `BCD_CLK_NS - 1) / `BCD_CLK_NS)

// Register byte offsets
`define BCD_OFF_CTRL 8'h00
`define BCD_OFF_STAT 8'h04
`define BCD_OFF_RDATA 8'h08

// Control register fields
`define BCD_CTRL_OP 2:0
`define BCD_CTRL_VAL 15:8

// Status register bits
`define BCD_STAT_BUSY 0
`define BCD_STAT_DONE 1
`define BCD_STAT_ATTN 2

// Busy position inside the device status byte
`define BCD_DEV_BUSY_BIT 4

// Idle levels of the inverted channel lines, then zero and one constants
`define BCD_LINE_IDLE 1'b1
`define BCD_BYTE_IDLE 8'hff
`define BCD_WORD_ZERO 32'h0000_0000
`define BCD_BYTE_ZERO 8'h00
`define BCD_CNT_ZERO 8'h00
`define BCD_CNT_ONE 8'h01

`endif

// File: hw/bcd_host.sv
`timescale 1ns/1ps
`include "bcd_consts.svh"

// Behaviour
// - Poll op waits for busy low before reading data; read op does not.
// - Host drops acknowledge after sync; queue clears.
// - Byte leads strobe 100 ns; strobe ends on sync.
// - Byte held 100 ns after strobe removal.
// - Channel lines inverted: ground means one.
module bcd_host (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Channel
  output bcd_pkg::bcd_chan_out_s chan_out,
  input wire bcd_pkg::bcd_chan_in_s chan_in
);

  // Idle state of every host-driven line
  function automatic bcd_pkg::bcd_chan_out_s idle_lines();
    bcd_pkg::bcd_chan_out_s s;
    s.host_out_lines_n = `BCD_BYTE_IDLE;
    s.address_strobe_n = `BCD_LINE_IDLE;
    s.data_strobe_n = `BCD_LINE_IDLE;
    s.command_strobe_n = `BCD_LINE_IDLE;
    s.status_request_n = `BCD_LINE_IDLE;
    s.data_request_n = `BCD_LINE_IDLE;
    s.ack_n = `BCD_LINE_IDLE;
    s.system_clear_n = `BCD_LINE_IDLE;
    return s;
  endfunction : idle_lines

  // Drive the control line that belongs to an operation
  function automatic bcd_pkg::bcd_chan_out_s set_strobe(
    input bcd_pkg::bcd_chan_out_s s_in,
    input bcd_pkg::bcd_op_e op,
    input logic phase,
    input logic on
  );
    bcd_pkg::bcd_chan_out_s s;
    logic lvl;
    s = s_in;
    lvl = ~on;
    case (op)
      bcd_pkg::OP_ADDR: s.address_strobe_n = lvl;
      bcd_pkg::OP_CMD: s.command_strobe_n = lvl;
      bcd_pkg::OP_WRITE: s.data_strobe_n = lvl;
      bcd_pkg::OP_STATUS: s.status_request_n = lvl;
      bcd_pkg::OP_READ: s.data_request_n = lvl;
      bcd_pkg::OP_POLL: begin
        if (phase) begin
          s.data_request_n = lvl;
        end else begin
          s.status_request_n = lvl;
        end
      end
      bcd_pkg::OP_ACK: s.ack_n = lvl;
      default: s.system_clear_n = lvl;
    endcase
    return s;
  endfunction : set_strobe

  // Synchronised channel inputs
  bcd_pkg::bcd_chan_in_s in_s;

  bcd_sync #(
    .W($bits(bcd_pkg::bcd_chan_in_s))
  ) u_sync (
    .mclk(mclk),
    .rst(rst),
    .d(chan_in),
    .q(in_s)
  );

  logic sync_seen;
  logic attn_seen;
  logic [7:0] in_byte;

  always_comb begin
    sync_seen = ~in_s.sync_reply_n;
    attn_seen = ~in_s.attention_line_n;
    in_byte = ~in_s.host_in_lines_n;
  end

  // Sequencer state
  bcd_pkg::bcd_state_e state_r;
  bcd_pkg::bcd_state_e state_nxt;
  bcd_pkg::bcd_op_e op_r;
  bcd_pkg::bcd_op_e op_nxt;
  logic phase_r;
  logic phase_nxt;
  logic [7:0] cnt_r;
  logic [7:0] cnt_nxt;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  bcd_pkg::bcd_chan_out_s out_r;
  bcd_pkg::bcd_chan_out_s out_nxt;
  logic fin;

  // Register bus state
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;
  logic pready_r;
  logic pready_nxt;
  logic pslverr_r;
  logic pslverr_nxt;
  logic done_r;
  logic done_nxt;
  logic start;
  bcd_pkg::bcd_op_e start_op;
  logic [7:0] start_val;

  logic is_output_op;

  always_comb begin
    is_output_op = is_out_op(start_op);
  end

  always_comb begin
    state_nxt = state_r;
    op_nxt = op_r;
    phase_nxt = phase_r;
    cnt_nxt = cnt_r;
    rdata_nxt = rdata_r;
    out_nxt = out_r;
    fin = 1'b0;
    case (state_r)
      bcd_pkg::ST_IDLE: begin
        if (start) begin
          op_nxt = start_op;
          phase_nxt = 1'b0;
          if (start_op == bcd_pkg::OP_CLEAR) begin
            out_nxt.system_clear_n = 1'b0;
            cnt_nxt = 8'(`BCD_CLR_CYC);
            state_nxt = bcd_pkg::ST_CLEAR;
          end else if (is_output_op) begin
            out_nxt.host_out_lines_n = ~start_val;
            cnt_nxt = 8'(`BCD_T1_CYC);
            state_nxt = bcd_pkg::ST_SETUP;
          end else begin
            // Input lines idle at zero so acks read the strap
            out_nxt = set_strobe(out_r, start_op, 1'b0, 1'b1);
            state_nxt = bcd_pkg::ST_STROBE;
          end
        end
      end
      bcd_pkg::ST_SETUP: begin
        if (cnt_r == `BCD_CNT_ZERO) begin
          out_nxt = set_strobe(out_r, op_r, phase_r, 1'b1);
          state_nxt = bcd_pkg::ST_STROBE;
        end else begin
          cnt_nxt = cnt_r - `BCD_CNT_ONE;
        end
      end
      bcd_pkg::ST_STROBE: begin
        // Device sync comes after its byte has settled
        if (sync_seen) begin
          out_nxt = set_strobe(out_r, op_r, phase_r, 1'b0);
          if (!is_out_op(op_r)) begin
            rdata_nxt = in_byte;
          end
          cnt_nxt = 8'(`BCD_T3_CYC);
          state_nxt = bcd_pkg::ST_RELEASE;
        end
      end
      bcd_pkg::ST_RELEASE: begin
        if (cnt_r != `BCD_CNT_ZERO) begin
          cnt_nxt = cnt_r - `BCD_CNT_ONE;
        end else if (!sync_seen) begin
          out_nxt.host_out_lines_n = `BCD_BYTE_IDLE;
          if (op_r == bcd_pkg::OP_POLL && !phase_r) begin
            // Keep asking status until busy reads low
            if (rdata_r[`BCD_DEV_BUSY_BIT]) begin
              out_nxt = set_strobe(idle_lines(), op_r, 1'b0, 1'b1);
            end else begin
              phase_nxt = 1'b1;
              out_nxt = set_strobe(idle_lines(), op_r, 1'b1, 1'b1);
            end
            state_nxt = bcd_pkg::ST_STROBE;
          end else begin
            fin = 1'b1;
            phase_nxt = 1'b0;
            state_nxt = bcd_pkg::ST_IDLE;
          end
        end
      end
      bcd_pkg::ST_CLEAR: begin
        if (cnt_r == `BCD_CNT_ZERO) begin
          out_nxt.system_clear_n = `BCD_LINE_IDLE;
          fin = 1'b1;
          state_nxt = bcd_pkg::ST_IDLE;
        end else begin
          cnt_nxt = cnt_r - `BCD_CNT_ONE;
        end
      end
      default: begin
        out_nxt = idle_lines();
        state_nxt = bcd_pkg::ST_IDLE;
      end
    endcase
  end

  // Output-direction operation test
  function automatic logic is_out_op(input bcd_pkg::bcd_op_e op);
    return (op == bcd_pkg::OP_ADDR) || (op == bcd_pkg::OP_CMD) ||
           (op == bcd_pkg::OP_WRITE);
  endfunction : is_out_op

  always_ff @(posedge mclk) begin
    if (rst) begin
      state_r <= bcd_pkg::ST_IDLE;
      op_r <= bcd_pkg::OP_ADDR;
      phase_r <= 1'b0;
      cnt_r <= `BCD_CNT_ZERO;
      rdata_r <= `BCD_BYTE_ZERO;
      out_r <= idle_lines();
    end else begin
      state_r <= state_nxt;
      op_r <= op_nxt;
      phase_r <= phase_nxt;
      cnt_r <= cnt_nxt;
      rdata_r <= rdata_nxt;
      out_r <= out_nxt;
    end
  end

  // APB slave: one wait state, decision made in first access cycle
  logic acc_first;
  logic acc_done;
  logic hit_ctrl;
  logic hit_stat;
  logic hit_rdata;
  logic clr_done;

  always_comb begin
    acc_first = psel && penable && !pready_r;
    acc_done = psel && penable && pready_r;
    hit_ctrl = (paddr == `BCD_OFF_CTRL);
    hit_stat = (paddr == `BCD_OFF_STAT);
    hit_rdata = (paddr == `BCD_OFF_RDATA);
    start_op = bcd_pkg::bcd_op_e'(pwdata[`BCD_CTRL_OP]);
    start_val = pwdata[`BCD_CTRL_VAL];
    start = acc_done && pwrite && hit_ctrl && !pslverr_r;
    clr_done = acc_done && pwrite && hit_stat && pwdata[`BCD_STAT_DONE];
  end

  always_comb begin
    prdata_nxt = prdata_r;
    pready_nxt = 1'b0;
    pslverr_nxt = 1'b0;
    // Completion outranks a software clear in the same cycle
    done_nxt = fin || (done_r && !clr_done);
    if (acc_first) begin
      pready_nxt = 1'b1;
      prdata_nxt = `BCD_WORD_ZERO;
      if (hit_ctrl) begin
        pslverr_nxt = pwrite && (state_r != bcd_pkg::ST_IDLE);
      end else if (hit_stat) begin
        prdata_nxt[`BCD_STAT_BUSY] = (state_r != bcd_pkg::ST_IDLE);
        prdata_nxt[`BCD_STAT_DONE] = done_r;
        prdata_nxt[`BCD_STAT_ATTN] = attn_seen;
      end else if (hit_rdata) begin
        prdata_nxt[7:0] = rdata_r;
        pslverr_nxt = pwrite;
      end else begin
        pslverr_nxt = 1'b1;
      end
    end else if (acc_done) begin
      pslverr_nxt = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      prdata_r <= `BCD_WORD_ZERO;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      done_r <= done_nxt;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign chan_out = out_r;

endmodule : bcd_host

// File: hw/bcd_pkg.sv
package bcd_pkg;

  typedef enum logic [2:0] {
    OP_ADDR   = 3'b000,
    OP_CMD    = 3'b001,
    OP_WRITE  = 3'b010,
    OP_STATUS = 3'b011,
    OP_READ   = 3'b100,
    OP_POLL   = 3'b101,
    OP_ACK    = 3'b110,
    OP_CLEAR  = 3'b111
  } bcd_op_e;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_SETUP   = 3'b001,
    ST_STROBE  = 3'b010,
    ST_RELEASE = 3'b011,
    ST_CLEAR   = 3'b100
  } bcd_state_e;

  // Host-driven channel lines, all active low
  typedef struct packed {
    logic [7:0] host_out_lines_n;
    logic address_strobe_n;
    logic data_strobe_n;
    logic command_strobe_n;
    logic status_request_n;
    logic data_request_n;
    logic ack_n;
    logic system_clear_n;
  } bcd_chan_out_s;

  // Device-driven channel lines, all active low
  typedef struct packed {
    logic [7:0] host_in_lines_n;
    logic sync_reply_n;
    logic attention_line_n;
  } bcd_chan_in_s;

endpackage : bcd_pkg

// File: hw/bcd_sync.sv
`timescale 1ns/1ps

module bcd_sync #(
  parameter int W = 10
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Asynchronous in, synchronous out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] q_r;
  logic [W-1:0] q_nxt;

  always_comb begin
    meta_nxt = d;
    q_nxt = meta_r;
  end

  // Idle level is all ones on the inverted channel
  always_ff @(posedge mclk) begin
    if (rst) begin
      meta_r <= '1;
      q_r <= '1;
    end else begin
      meta_r <= meta_nxt;
      q_r <= q_nxt;
    end
  end

  assign q = q_r;

endmodule : bcd_sync

// File: test/bcd_dev.sv
`timescale 1ns/1ps
module bcd_dev #(
  parameter logic [7:0] ADDR = 8'h02
) (
  // Channel
  input wire bcd_pkg::bcd_chan_out_s co,
  input wire logic ack_in_n,
  output logic ack_out_n,
  output bcd_pkg::bcd_chan_in_s ci,
  // Device side
  input wire logic irq,
  input wire logic [2:0] flags,
  input wire logic [7:0] rdat,
  output logic [7:0] wdat,
  output logic [3:0] ctl,
  output logic sel
);
  logic [7:0] o;
  logic [7:0] st;
  logic [7:0] lin_n;
  logic [1:0] scnt;
  logic q;
  logic aq;
  logic rsy;
  logic syn_n;
  initial {sel, q, aq, ctl, wdat, scnt} = '0;
  assign o = ~co.host_out_lines_n;
  assign st = {flags[2], 1'b0, flags[1], scnt != 2'h2, 1'b0, flags[0],
    2'h0};
  assign rsy = (!co.address_strobe_n && o == ADDR) || (aq && !ack_in_n)
    || (sel && !(co.status_request_n && co.data_request_n
    && co.data_strobe_n && co.command_strobe_n));
  assign #200 syn_n = !rsy;
  assign lin_n = ~(sel && !co.status_request_n ? st
    : sel && !co.data_request_n ? rdat
    : aq && !ack_in_n ? ADDR : 8'h00);
  assign ci = {lin_n, syn_n, ~q};
  assign ack_out_n = ack_in_n | aq;
  always @(negedge co.address_strobe_n) sel = o == ADDR;
  always @(negedge co.system_clear_n) begin
    {sel, q, ctl, scnt} = '0;
  end
  // Busy for two status reads after each data read
  always @(posedge co.status_request_n) begin
    if (sel && scnt != 2'h2) scnt = scnt + 2'h1;
  end
  always @(posedge co.data_request_n) if (sel) scnt = 2'h0;
  always @(negedge co.data_strobe_n) if (sel) wdat = o;
  always @(negedge co.command_strobe_n) begin
    if (sel) for (int i = 0; i < 4; i++)
      ctl[i] = (ctl[i] | o[2*i]) & ~o[2*i+1];
  end
  always @(posedge irq) if (ctl[1]) q = 1'b1;
  always @(negedge ack_in_n) aq = q;
  always @(posedge ack_in_n) if (aq) {q, aq} = 2'h0;
endmodule : bcd_dev

// File: test/bcd_host_sva.sv
`timescale 1ns/1ps
module bcd_host_sva (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Channel
  input wire bcd_pkg::bcd_chan_out_s chan_out,
  input wire bcd_pkg::bcd_chan_in_s chan_in
);
  logic [7:0] clr_r;
  logic [7:0] clr_nxt;
  logic out_n;
  logic any_n;
  assign out_n = chan_out.address_strobe_n & chan_out.data_strobe_n
    & chan_out.command_strobe_n;
  assign any_n = out_n & chan_out.status_request_n
    & chan_out.data_request_n & chan_out.ack_n;
  // Length of the clear pulse so far
  always_comb begin
    clr_nxt = chan_out.system_clear_n ? 8'h00 : clr_r + 8'h01;
  end
  always_ff @(posedge mclk) begin
    clr_r <= clr_nxt;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  a_idle_reset: assert property (disable iff (1'b0)
    rst |=> chan_out == 15'h7fff) else $error("channel busy in reset");
  a_ready_wait: assert property ($rose(penable) && psel |=> pready)
    else $error("pready late");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready too long");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_byte_lead: assert property ($fell(out_n) |->
    $past(chan_out.host_out_lines_n, 5) == chan_out.host_out_lines_n)
    else $error("byte not ahead of strobe");
  a_byte_hold: assert property ($rose(out_n) |=>
    $stable(chan_out.host_out_lines_n) [*5]) else $error("byte dropped");
  a_end_on_sync: assert property ($rose(any_n) |->
    !$past(chan_in.sync_reply_n, 2)) else $error("strobe ended early");
  a_one_strobe: assert property ($onehot0(~{chan_out.address_strobe_n,
    chan_out.data_strobe_n, chan_out.command_strobe_n,
    chan_out.status_request_n, chan_out.data_request_n, chan_out.ack_n}))
    else $error("two strobes at once");
  a_ack_zero: assert property (!chan_out.ack_n |->
    chan_out.host_out_lines_n == 8'hff) else $error("byte during ack");
  a_clear_len: assert property ($rose(chan_out.system_clear_n) |->
    clr_r >= 8'h32) else $error("clear pulse short");
endmodule : bcd_host_sva

bind bcd_host bcd_host_sva u_sva (.mclk(mclk), .rst(rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .chan_out(chan_out), .chan_in(chan_in));

// File: test/testbench.sv
`timescale 1ns/1ps
`define CHK(n, e, a) begin tests_run++; if ((a) !== (e)) begin \
  n_errors++; $display("BAD %s exp %h got %h", n, e, a); end end
module testbench;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  bcd_pkg::bcd_chan_out_s co;
  bcd_pkg::bcd_chan_in_s ci0;
  bcd_pkg::bcd_chan_in_s ci1;
  logic ack_mid_n;
  logic [1:0] irq = 2'h0;
  logic [2:0] flg0 = 3'h5;
  logic [7:0] rdt0 = 8'h3c;
  logic [7:0] wd0;
  logic [7:0] wd1;
  logic [3:0] ctl0;
  logic [3:0] ctl1;
  logic sel0;
  logic sel1;
  logic [31:0] rv;
  logic err;
  int n_errors = 0;
  int tests_run = 0;
  int cyc = 0;
  always #10 mclk = ~mclk;
  bcd_host dut (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .chan_out(co), .chan_in(ci0 & ci1));
  bcd_dev #(.ADDR(8'h02)) dev0 (.co(co), .ack_in_n(co.ack_n),
    .ack_out_n(ack_mid_n), .ci(ci0), .irq(irq[0]), .flags(flg0),
    .rdat(rdt0), .wdat(wd0), .ctl(ctl0), .sel(sel0));
  bcd_dev #(.ADDR(8'h03)) dev1 (.co(co), .ack_in_n(ack_mid_n),
    .ack_out_n(), .ci(ci1), .irq(irq[1]), .flags(3'h2),
    .rdat(8'hc3), .wdat(wd1), .ctl(ctl1), .sel(sel1));
  task automatic finish_test();
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : finish_test
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      finish_test();
    end
  end
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wait_done();
    rv = 32'h0;
    while (rv[1] !== 1'b1) apb(1'b0, 8'h04, 32'h0);
    apb(1'b1, 8'h04, 32'h2);
  endtask : wait_done
  task automatic op(input logic [2:0] c, input logic [7:0] b);
    apb(1'b1, 8'h00, {16'h0, b, 5'h0, c});
    wait_done();
  endtask : op
  task automatic rd_byte();
    apb(1'b0, 8'h08, 32'h0);
  endtask : rd_byte
  initial begin
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    `CHK("idle", 15'h7fff, co)
    op(bcd_pkg::OP_ADDR, 8'h02);
    `CHK("select", 2'b01, {sel1, sel0})
    op(bcd_pkg::OP_STATUS, 8'h00);
    rd_byte();
    `CHK("status", 32'h94, rv)
    op(bcd_pkg::OP_WRITE, 8'ha5);
    `CHK("wdata", 8'ha5, wd0)
    op(bcd_pkg::OP_CMD, 8'h05);
    `CHK("cmd set", 4'h3, ctl0)
    op(bcd_pkg::OP_CMD, 8'h82);
    `CHK("cmd clear", 4'h2, ctl0)
    op(bcd_pkg::OP_POLL, 8'h00);
    rd_byte();
    `CHK("poll data", 32'h3c, rv)
    flg0 <= 3'h2;
    op(bcd_pkg::OP_STATUS, 8'h00);
    rd_byte();
    `CHK("examine", 32'h30, rv)
    irq[0] <= 1'b1;
    repeat (4) @(posedge mclk);
    apb(1'b0, 8'h04, 32'h0);
    `CHK("attention", 1'b1, rv[2])
    op(bcd_pkg::OP_ACK, 8'h00);
    rd_byte();
    `CHK("ack id", 32'h02, rv)
    apb(1'b0, 8'h04, 32'h0);
    `CHK("attention off", 1'b0, rv[2])
    op(bcd_pkg::OP_ADDR, 8'h03);
    `CHK("reselect", 2'b10, {sel1, sel0})
    op(bcd_pkg::OP_WRITE, 8'h5a);
    `CHK("other wdata", 16'h5aa5, {wd1, wd0})
    op(bcd_pkg::OP_READ, 8'h00);
    rd_byte();
    `CHK("read data", 32'hc3, rv)
    op(bcd_pkg::OP_CMD, 8'h04);
    irq[1] <= 1'b1;
    op(bcd_pkg::OP_ACK, 8'h00);
    rd_byte();
    `CHK("chain id", 32'h03, rv)
    op(bcd_pkg::OP_CMD, 8'h08);
    irq[1] <= 1'b0;
    @(posedge mclk);
    irq[1] <= 1'b1;
    repeat (4) @(posedge mclk);
    apb(1'b0, 8'h04, 32'h0);
    `CHK("masked", 1'b0, rv[2])
    apb(1'b0, 8'h0c, 32'h0);
    `CHK("unmapped", 33'h1_0000_0000, {err, rv})
    apb(1'b1, 8'h08, 32'h1);
    `CHK("ro write", 1'b1, err)
    apb(1'b1, 8'h00, 32'h7);
    apb(1'b1, 8'h00, 32'h0);
    `CHK("busy write", 1'b1, err)
    wait_done();
    `CHK("cleared", 6'h00, {sel1, sel0, ctl0})
    finish_test();
  end
endmodule : testbench
